// [hw/ssb_pkg.sv]
// Purpose : Shared constants for the banked sensor configuration registers.
// Assumes : 7-bit register address, 8-bit register data, four banks.
// Notes   : Bank 1 holds nothing in this block and reads as zero.
package ssb_pkg;

    // ==========================================================
    // Access widths
    localparam int          ADDR_W         = 7;
    localparam int          DATA_W         = 8;
    localparam int          BANK_W         = 2;

    // ==========================================================
    // Bank codes
    localparam logic [1:0]  BANK_0         = 2'h0;
    localparam logic [1:0]  BANK_1         = 2'h1;
    localparam logic [1:0]  BANK_2         = 2'h2;
    localparam logic [1:0]  BANK_3         = 2'h3;

    // ==========================================================
    // Register addresses
    localparam logic [6:0]  ADDR_BANK_SEL  = 7'h00;
    localparam logic [6:0]  ADDR_HOLD      = 7'h01;
    localparam logic [6:0]  ADDR_FS_DIS    = 7'h02;
    localparam logic [6:0]  ADDR_GRAN      = 7'h05;
    localparam logic [6:0]  ADDR_CLKGEN    = 7'h06;
    localparam logic [6:0]  ADDR_PLL_GATE  = 7'h31;
    localparam logic [6:0]  ADDR_TMUX      = 7'h63;
    localparam logic [6:0]  ADDR_TG_LO     = 7'h6E;
    localparam logic [6:0]  ADDR_TG_HI     = 7'h6F;
    localparam logic [6:0]  ADDR_SHUT_LO   = 7'h72;
    localparam logic [6:0]  ADDR_SHUT_HI   = 7'h73;

    // ==========================================================
    // Field widths and positions
    localparam int          GRAN_W         = 8;
    localparam int          PHASE_W        = 2;
    localparam int          PHASE_LSB      = 1;
    localparam int          TMUX_W         = 5;
    localparam int          LEN_W          = 14;
    localparam int          LEN_HI_W       = 6;

    // ==========================================================
    // Reset values
    localparam logic [1:0]  RST_BANK_SEL   = 2'h0;
    localparam logic        RST_HOLD       = 1'h0;
    localparam logic        RST_FS_DIS     = 1'h0;
    localparam logic [7:0]  RST_GRAN       = 8'h00;
    localparam logic [1:0]  RST_PHASE      = 2'h0;
    localparam logic [4:0]  RST_TMUX       = 5'h00;
    localparam logic [13:0] RST_TG_LEN     = 14'h0000;
    localparam logic [13:0] RST_SHUT       = 14'h0000;
    localparam logic        RST_PLL_GATE   = 1'h0;

endpackage : ssb_pkg

// [hw/ssb_shadow_reg.sv]
// Purpose : One configuration field with a host-written shadow and an applied copy.
// Assumes : Caller builds the full field value for partial (byte) writes.
// Notes   : When apply and a write meet, the applied copy takes the new value.
`timescale 1ns/1ps
module ssb_shadow_reg #(
    parameter int           W       = 8,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_data,
    input  wire logic         apply,
    output logic      [W-1:0] shadow,
    output logic      [W-1:0] active
);

    typedef struct packed {
        logic [W-1:0] shadow;
        logic [W-1:0] active;
    } ssb_field_state_t;

    ssb_field_state_t st;
    ssb_field_state_t next_st;

    // ==========================================================
    // Next state
    always_comb begin
        next_st = st;
        if (wr_en) begin
            next_st.shadow = wr_data;
        end
        // Apply the value as it will stand, so a write in the apply cycle is not missed
        if (apply) begin
            next_st.active = next_st.shadow;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{shadow: RST_VAL, active: RST_VAL};
        end else begin
            st <= next_st;
        end
    end

    assign shadow = st.shadow;
    assign active = st.active;

endmodule : ssb_shadow_reg

// [hw/ssb_bank_regs.sv]
// Purpose : Banked configuration registers behind the sensor's serial control port.
// Assumes : Serial deframing is done outside; one-cycle read/write strobes arrive on CLK.
// Notes   : Bank 2/3 fields are shadowed; their applied copies drive the sensor core.
//
// What this block does
// [RULE_01] A two-bit bank selector at address 0, reset to zero, routes all later accesses other than address 0 to bank 0 to 3.
// [RULE_02] Hold clear applies new parameters at the next frame sync; hold set applies them during the upload.
// [RULE_03] The frame-sync disable bit in bank 0 suppresses frame synchronisation when set and not when clear.
// [RULE_04] Bank 2 carries the 14-bit timing length at 110/111 and lag at 114/115, phase in bits 2:1 of 6, mux at 99.
// [RULE_05] Reserved addresses and bits read as zero and writes to them change nothing.
`timescale 1ns/1ps
module ssb_bank_regs
    import ssb_pkg::*;
(
    input  wire logic              CLK,
    input  wire logic              RST_N,
    input  wire logic              REG_WR,
    input  wire logic              REG_RD,
    input  wire logic [ADDR_W-1:0] REG_ADDR,
    input  wire logic [DATA_W-1:0] REG_WDATA,
    input  wire logic              FRAME_SYNC_IN,
    output logic      [DATA_W-1:0] REG_RDATA,
    output logic                   REG_RVALID,
    output logic      [BANK_W-1:0] BANK_SELECT,
    output logic                   PARAMETER_UPDATE_HOLD,
    output logic                   FRAME_SYNC_DISABLE,
    output logic                   FRAME_SYNC_OUT,
    output logic      [GRAN_W-1:0] GLOBAL_GRANULARITY,
    output logic     [PHASE_W-1:0] CLOCK_PHASE_SELECT,
    output logic      [TMUX_W-1:0] TEST_MUX_SELECT,
    output logic       [LEN_W-1:0] TIMING_GEN_LENGTH,
    output logic       [LEN_W-1:0] SHUTTER_DELAY_COUNT,
    output logic                   PLL_OUTPUT_GATE
);

    typedef struct packed {
        logic [1:0] bank_sel;
        logic       hold;
        logic       fs_dis;
        logic [2:0] fs_sync;    // [0] meta, [1] stable, [2] delayed for edge
        logic       fs_out;
        logic [7:0] rdata;
        logic       rvalid;
    } ssb_top_state_t;

    ssb_top_state_t st;
    ssb_top_state_t next_st;

    // Field write strobes and write values
    logic              wr_gran;
    logic              wr_phase;
    logic              wr_tmux;
    logic              wr_tg;
    logic              wr_shut;
    logic              wr_pll;
    logic [LEN_W-1:0]  tg_wval;
    logic [LEN_W-1:0]  shut_wval;
    logic              fs_rise;
    logic              apply;

    // Shadow values (what the host reads back)
    logic [GRAN_W-1:0]  gran_sh;
    logic [PHASE_W-1:0] phase_sh;
    logic [TMUX_W-1:0]  tmux_sh;
    logic [LEN_W-1:0]   tg_sh;
    logic [LEN_W-1:0]   shut_sh;
    logic               pll_sh;

    // ==========================================================
    // Write decode for shadowed fields
    always_comb begin
        // [RULE_01] Bank routes writes
        wr_gran   = REG_WR && st.bank_sel == BANK_2 && REG_ADDR == ADDR_GRAN;
        wr_phase  = REG_WR && st.bank_sel == BANK_2 && REG_ADDR == ADDR_CLKGEN;
        wr_tmux   = REG_WR && st.bank_sel == BANK_2 && REG_ADDR == ADDR_TMUX;
        wr_pll    = REG_WR && st.bank_sel == BANK_3 && REG_ADDR == ADDR_PLL_GATE;
        // [RULE_04] Split length bytes
        wr_tg     = REG_WR && st.bank_sel == BANK_2 && (REG_ADDR == ADDR_TG_LO || REG_ADDR == ADDR_TG_HI);
        wr_shut   = REG_WR && st.bank_sel == BANK_2 && (REG_ADDR == ADDR_SHUT_LO || REG_ADDR == ADDR_SHUT_HI);
        // Each byte write keeps the other byte of the field intact
        tg_wval   = (REG_ADDR == ADDR_TG_LO) ? {tg_sh[LEN_W-1:DATA_W], REG_WDATA}
                                             : {REG_WDATA[LEN_HI_W-1:0], tg_sh[DATA_W-1:0]};
        shut_wval = (REG_ADDR == ADDR_SHUT_LO) ? {shut_sh[LEN_W-1:DATA_W], REG_WDATA}
                                               : {REG_WDATA[LEN_HI_W-1:0], shut_sh[DATA_W-1:0]};
    end

    // ==========================================================
    // Frame sync edge and parameter apply
    // [RULE_03] Disable gates sync
    assign fs_rise = st.fs_sync[1] && !st.fs_sync[2] && !st.fs_dis;
    // [RULE_02] Hold selects apply
    assign apply   = st.hold || fs_rise;

    // ==========================================================
    // Control, sync and read path
    always_comb begin
        next_st        = st;
        next_st.fs_sync = {st.fs_sync[1:0], FRAME_SYNC_IN};
        next_st.fs_out = fs_rise;
        next_st.rvalid = REG_RD;
        // [RULE_01] Selector at address 0
        if (REG_WR && REG_ADDR == ADDR_BANK_SEL) begin
            next_st.bank_sel = REG_WDATA[BANK_W-1:0];
        end
        if (REG_WR && st.bank_sel == BANK_0 && REG_ADDR == ADDR_HOLD) begin
            next_st.hold = REG_WDATA[0];
        end
        // [RULE_03] Disable bit write
        if (REG_WR && st.bank_sel == BANK_0 && REG_ADDR == ADDR_FS_DIS) begin
            next_st.fs_dis = REG_WDATA[0];
        end
        // [RULE_05] Unmapped reads zero
        if (REG_RD) begin
            next_st.rdata = 8'h00;
            if (REG_ADDR == ADDR_BANK_SEL) begin
                next_st.rdata = {6'h00, st.bank_sel};
            end else begin
                case (st.bank_sel)
                    BANK_0: begin
                        if (REG_ADDR == ADDR_HOLD) next_st.rdata = {7'h00, st.hold};
                        if (REG_ADDR == ADDR_FS_DIS) next_st.rdata = {7'h00, st.fs_dis};
                    end
                    BANK_2: begin
                        case (REG_ADDR)
                            ADDR_GRAN:    next_st.rdata = gran_sh;
                            ADDR_CLKGEN:  next_st.rdata = {5'h00, phase_sh, 1'h0};
                            ADDR_TMUX:    next_st.rdata = {3'h0, tmux_sh};
                            ADDR_TG_LO:   next_st.rdata = tg_sh[DATA_W-1:0];
                            ADDR_TG_HI:   next_st.rdata = {2'h0, tg_sh[LEN_W-1:DATA_W]};
                            ADDR_SHUT_LO: next_st.rdata = shut_sh[DATA_W-1:0];
                            ADDR_SHUT_HI: next_st.rdata = {2'h0, shut_sh[LEN_W-1:DATA_W]};
                            default:      next_st.rdata = 8'h00;
                        endcase
                    end
                    BANK_3: begin
                        if (REG_ADDR == ADDR_PLL_GATE) next_st.rdata = {7'h00, pll_sh};
                    end
                    default: next_st.rdata = 8'h00;
                endcase
            end
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st <= '{bank_sel: RST_BANK_SEL, hold: RST_HOLD, fs_dis: RST_FS_DIS,
                    fs_sync: 3'h0, fs_out: 1'h0, rdata: 8'h00, rvalid: 1'h0};
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Shadowed fields, applied on frame sync or while holding
    // Global granularity takes the whole data byte
    ssb_shadow_reg #(
        .W       (GRAN_W),
        .RST_VAL (RST_GRAN)
    ) u_gran (
        .clk     (CLK),
        .rst_n   (RST_N),
        .wr_en   (wr_gran),
        .wr_data (REG_WDATA),
        .apply   (apply),
        .shadow  (gran_sh),
        .active  (GLOBAL_GRANULARITY)
    );

    // [RULE_04] Phase in bits 2:1
    ssb_shadow_reg #(
        .W       (PHASE_W),
        .RST_VAL (RST_PHASE)
    ) u_phase (
        .clk     (CLK),
        .rst_n   (RST_N),
        .wr_en   (wr_phase),
        .wr_data (REG_WDATA[PHASE_LSB+PHASE_W-1:PHASE_LSB]),
        .apply   (apply),
        .shadow  (phase_sh),
        .active  (CLOCK_PHASE_SELECT)
    );

    // Test mux keeps only the low five bits; the upper three are reserved
    ssb_shadow_reg #(
        .W       (TMUX_W),
        .RST_VAL (RST_TMUX)
    ) u_tmux (
        .clk     (CLK),
        .rst_n   (RST_N),
        .wr_en   (wr_tmux),
        .wr_data (REG_WDATA[TMUX_W-1:0]),
        .apply   (apply),
        .shadow  (tmux_sh),
        .active  (TEST_MUX_SELECT)
    );

    // Timing length: the two byte writes merge in the shadow, one apply moves all 14 bits
    ssb_shadow_reg #(
        .W       (LEN_W),
        .RST_VAL (RST_TG_LEN)
    ) u_tg (
        .clk     (CLK),
        .rst_n   (RST_N),
        .wr_en   (wr_tg),
        .wr_data (tg_wval),
        .apply   (apply),
        .shadow  (tg_sh),
        .active  (TIMING_GEN_LENGTH)
    );

    // Shutter_delay_count, split the same way; a sync between the two byte writes applies the half-written value
    ssb_shadow_reg #(
        .W       (LEN_W),
        .RST_VAL (RST_SHUT)
    ) u_shut (
        .clk     (CLK),
        .rst_n   (RST_N),
        .wr_en   (wr_shut),
        .wr_data (shut_wval),
        .apply   (apply),
        .shadow  (shut_sh),
        .active  (SHUTTER_DELAY_COUNT)
    );

    // PLL output gate in bank 3, shadowed like the bank 2 fields
    ssb_shadow_reg #(
        .W       (1),
        .RST_VAL (RST_PLL_GATE)
    ) u_pll (
        .clk     (CLK),
        .rst_n   (RST_N),
        .wr_en   (wr_pll),
        .wr_data (REG_WDATA[0]),
        .apply   (apply),
        .shadow  (pll_sh),
        .active  (PLL_OUTPUT_GATE)
    );

    // ==========================================================
    // Direct outputs
    assign REG_RDATA             = st.rdata;
    assign REG_RVALID            = st.rvalid;
    assign BANK_SELECT           = st.bank_sel;
    assign PARAMETER_UPDATE_HOLD = st.hold;
    assign FRAME_SYNC_DISABLE    = st.fs_dis;
    assign FRAME_SYNC_OUT        = st.fs_out;

endmodule : ssb_bank_regs

// [dv/ssb_properties.sv]
// Purpose : Port-level checks of the banked sensor configuration registers.
// Assumes : One clock domain; RST_N asynchronous, active low.
// Notes   : Frame sync latency is bounded loosely to cover the two-flop synchroniser.
`timescale 1ns/1ps
module ssb_properties
    import ssb_pkg::*;
(
    input  wire logic              CLK,
    input  wire logic              RST_N,
    input  wire logic              REG_WR,
    input  wire logic              REG_RD,
    input  wire logic [ADDR_W-1:0] REG_ADDR,
    input  wire logic [DATA_W-1:0] REG_WDATA,
    input  wire logic              FRAME_SYNC_IN,
    input  wire logic [DATA_W-1:0] REG_RDATA,
    input  wire logic              REG_RVALID,
    input  wire logic [BANK_W-1:0] BANK_SELECT,
    input  wire logic              PARAMETER_UPDATE_HOLD,
    input  wire logic              FRAME_SYNC_DISABLE,
    input  wire logic              FRAME_SYNC_OUT,
    input  wire logic [TMUX_W-1:0] TEST_MUX_SELECT,
    input  wire logic  [LEN_W-1:0] TIMING_GEN_LENGTH
);
    // ==========================================================
    // Checks, all on the rising edge and idle during reset
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // Selector writes are decoded in every bank
    wire sel_wr = REG_WR && REG_ADDR == ADDR_BANK_SEL;
    chk_bank_write: assert property (sel_wr |=> BANK_SELECT == $past(REG_WDATA[1:0]))
        else $error("bank selector missed a write");
    chk_bank_steady: assert property (!sel_wr |=> $stable(BANK_SELECT))
        else $error("bank selector moved without a write");
    chk_read_latency: assert property (REG_RVALID == $past(REG_RD))
        else $error("read answer not one cycle after the strobe");
    chk_hold_write: assert property (REG_WR && BANK_SELECT == BANK_0 && REG_ADDR == ADDR_HOLD
        |=> PARAMETER_UPDATE_HOLD == $past(REG_WDATA[0]))
        else $error("hold bit missed a write");
    chk_hold_apply: assert property (PARAMETER_UPDATE_HOLD && REG_WR && BANK_SELECT == BANK_2
        && REG_ADDR == ADDR_TMUX
        |=> TEST_MUX_SELECT == $past(REG_WDATA[TMUX_W-1:0]))
        else $error("held field not applied during upload");
    chk_sync_only: assert property ($changed(TIMING_GEN_LENGTH) && !$past(PARAMETER_UPDATE_HOLD)
        |-> FRAME_SYNC_OUT)
        else $error("length applied outside a frame sync");
    chk_fsdis_write: assert property (REG_WR && BANK_SELECT == BANK_0 && REG_ADDR == ADDR_FS_DIS
        |=> FRAME_SYNC_DISABLE == $past(REG_WDATA[0]))
        else $error("sync disable missed a write");
    chk_sync_pulse: assert property ($rose(FRAME_SYNC_IN) && !FRAME_SYNC_DISABLE |-> ##[1:5] FRAME_SYNC_OUT)
        else $error("frame sync pulse missing");
    chk_sync_block: assert property (FRAME_SYNC_DISABLE && $past(FRAME_SYNC_DISABLE) |-> !FRAME_SYNC_OUT)
        else $error("frame sync pulse while disabled");
    chk_bank1_zero: assert property (REG_RD && BANK_SELECT == BANK_1 && REG_ADDR != ADDR_BANK_SEL
        |=> REG_RDATA == '0)
        else $error("empty bank read not zero");
endmodule : ssb_properties

bind ssb_bank_regs ssb_properties i_chk (.CLK(CLK), .RST_N(RST_N), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .FRAME_SYNC_IN(FRAME_SYNC_IN), .REG_RDATA(REG_RDATA),
    .REG_RVALID(REG_RVALID), .BANK_SELECT(BANK_SELECT), .PARAMETER_UPDATE_HOLD(PARAMETER_UPDATE_HOLD),
    .FRAME_SYNC_DISABLE(FRAME_SYNC_DISABLE), .FRAME_SYNC_OUT(FRAME_SYNC_OUT),
    .TEST_MUX_SELECT(TEST_MUX_SELECT), .TIMING_GEN_LENGTH(TIMING_GEN_LENGTH));

// [dv/ssb_host_model.sv]
// Purpose : Host side of the control port: one-cycle read and write strobes.
// Assumes : Strobes change just after a rising edge.
// Notes   : Idle address and data show the inverse of the last value, so stale data never matches.
`timescale 1ns/1ps
module ssb_host_model
    import ssb_pkg::*;
(
    input  wire logic              CLK,
    output logic                   REG_WR,
    output logic                   REG_RD,
    output logic      [ADDR_W-1:0] REG_ADDR,
    output logic      [DATA_W-1:0] REG_WDATA,
    input  wire logic [DATA_W-1:0] REG_RDATA,
    input  wire logic              REG_RVALID
);
    // ==========================================================
    // Idle lines at time zero
    initial begin
        REG_WR    = 1'b0;
        REG_RD    = 1'b0;
        REG_ADDR  = '0;
        REG_WDATA = '0;
    end
    // One access: strobe for one edge, then release
    task automatic put(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge CLK);
        REG_WR    <= wr;
        REG_RD    <= !wr;
        REG_ADDR  <= a;
        REG_WDATA <= d;
        @(posedge CLK);
        REG_WR    <= 1'b0;
        REG_RD    <= 1'b0;
        REG_ADDR  <= ~a;
        REG_WDATA <= ~d;
    endtask : put
    // Read answer is looked at in the one cycle that it stands
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic ok);
        put(1'b0, a, REG_WDATA);
        @(negedge CLK);
        ok = REG_RVALID;
        d  = REG_RDATA;
    endtask : rd
endmodule : ssb_host_model

// [dv/testbench.sv]
// Purpose : Self-checking bench of the banked sensor configuration registers.
// Assumes : Host model drives the port; bench drives reset and the sync pin.
// Notes   : One random pass follows an all-ones corner pass.
`timescale 1ns/1ps
module testbench
    import ssb_pkg::*;
;
    logic clk, rst_n, fs_in, wr, rd, rvalid, hold, fs_dis, fs_out, pll;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [BANK_W-1:0] bank;
    logic [PHASE_W-1:0] phase;
    logic [TMUX_W-1:0] tmux;
    logic [GRAN_W-1:0] gran;
    logic [LEN_W-1:0] tg, shut;
    int mismatches, samples_checked;
    ssb_host_model host (.CLK(clk), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_RDATA(rdata), .REG_RVALID(rvalid));
    ssb_bank_regs i_ssb_bank_regs (.CLK(clk), .RST_N(rst_n), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
        .REG_WDATA(wdata), .FRAME_SYNC_IN(fs_in), .REG_RDATA(rdata), .REG_RVALID(rvalid), .BANK_SELECT(bank),
        .PARAMETER_UPDATE_HOLD(hold), .FRAME_SYNC_DISABLE(fs_dis), .FRAME_SYNC_OUT(fs_out), .GLOBAL_GRANULARITY(gran),
        .CLOCK_PHASE_SELECT(phase), .TEST_MUX_SELECT(tmux), .TIMING_GEN_LENGTH(tg),
        .SHUTTER_DELAY_COUNT(shut), .PLL_OUTPUT_GATE(pll));
    // ==========================================================
    // Compare, report and close
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    // Write, then let the edge's updates land before anything is sampled
    task automatic w(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        host.put(1'b1, a, d);
        @(negedge clk);
    endtask : w
    // A missing answer counts as a mismatch and ends the run
    task automatic rdchk(input string what, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] d;
        logic              ok;
        host.rd(a, d, ok);
        chk(what, 16'(d), 16'(exp));
        if (ok !== 1'b1) begin
            mismatches++;
            stop_test();
        end
    endtask : rdchk
    // Pulse the sync pin and count output pulses over a fixed window
    task automatic fsync(input int exp);
        int seen;
        seen = 0;
        @(posedge clk);
        fs_in <= 1'b1;
        repeat (2) @(posedge clk);
        fs_in <= 1'b0;
        repeat (10) begin
            @(negedge clk);
            if (fs_out === 1'b1) seen++;
        end
        chk("sync_pulses", 16'(seen), 16'(exp));
    endtask : fsync
    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Main sequence
    initial begin
        logic [DATA_W-1:0] lo, hi, d6, dm;
        logic [15:0]       etg;
        mismatches = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        fs_in = 1'b0;
        etg = 16'(RST_TG_LEN);
        void'($urandom(32'h3E40DDE5));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        chk("bank", 16'(bank), 16'(RST_BANK_SEL));
        chk("hold", 16'(hold), 16'(RST_HOLD));
        chk("fs_dis", 16'(fs_dis), 16'(RST_FS_DIS));
        for (int b = 3; b >= 0; b--) begin
            w(ADDR_BANK_SEL, 8'(b));
            rdchk("bank_sel", ADDR_BANK_SEL, 8'(b));
        end
        $display("test reset_and_select done");
        w(ADDR_BANK_SEL, 8'(BANK_1));
        w(ADDR_GRAN, 8'hFF);
        rdchk("bank1_gran", ADDR_GRAN, 8'h00);
        w(ADDR_BANK_SEL, 8'(BANK_2));
        for (int i = 0; i < 2; i++) begin
            lo = i ? 8'($urandom) : 8'hFF;
            hi = i ? 8'($urandom) : 8'hFF;
            d6 = i ? 8'($urandom) : 8'hFF;
            dm = i ? 8'($urandom) : 8'hFF;
            w(ADDR_TG_LO, lo);
            w(ADDR_TG_HI, hi);
            w(ADDR_SHUT_LO, hi);
            w(ADDR_SHUT_HI, lo);
            w(ADDR_CLKGEN, d6);
            w(ADDR_TMUX, dm);
            w(ADDR_GRAN, d6);
            w(7'h70, 8'hFF);
            rdchk("tg_hi", ADDR_TG_HI, hi & 8'h3F);
            rdchk("shut_lo", ADDR_SHUT_LO, hi);
            rdchk("clkgen", ADDR_CLKGEN, d6 & 8'h06);
            rdchk("tmux_rd", ADDR_TMUX, dm & 8'h1F);
            rdchk("reserved", 7'h70, 8'h00);
            rdchk("gran_rd", ADDR_GRAN, d6);
            chk("gran_before_sync", 16'(gran), i ? 16'h00FF : 16'(RST_GRAN));
            chk("tg_before_sync", 16'(tg), etg);
            fsync(1);
            etg = {2'h0, hi[5:0], lo};
            chk("tg_len", 16'(tg), etg);
            chk("shut", 16'(shut), {2'h0, lo[5:0], hi});
            chk("phase", 16'(phase), 16'(d6[2:1]));
            chk("tmux", 16'(tmux), 16'(dm[4:0]));
            chk("gran", 16'(gran), 16'(d6));
        end
        $display("test bank2_fields done");
        w(ADDR_BANK_SEL, 8'(BANK_0));
        w(ADDR_FS_DIS, 8'h01);
        chk("fs_dis_set", 16'(fs_dis), 16'h0001);
        w(ADDR_BANK_SEL, 8'(BANK_2));
        w(ADDR_TG_LO, ~lo);
        fsync(0);
        chk("tg_blocked", 16'(tg), etg);
        w(ADDR_BANK_SEL, 8'(BANK_0));
        w(ADDR_FS_DIS, 8'h00);
        w(ADDR_HOLD, 8'h01);
        chk("hold_set", 16'(hold), 16'h0001);
        w(ADDR_BANK_SEL, 8'(BANK_2));
        etg = {2'h0, hi[5:0], ~lo};
        chk("tg_held", 16'(tg), etg);
        dm = 8'($urandom);
        w(ADDR_TMUX, dm);
        chk("tmux_held", 16'(tmux), 16'(dm[4:0]));
        w(ADDR_BANK_SEL, 8'(BANK_3));
        w(ADDR_PLL_GATE, 8'hFF);
        chk("pll_gate", 16'(pll), 16'h0001);
        rdchk("pll_rd", ADDR_PLL_GATE, 8'h01);
        $display("test disable_and_hold done");
        stop_test();
    end
endmodule : testbench
